// ===== pkg/bdf_pkg.sv
// bdf_pkg: shared constants for the bidirectional two-way fifo block
// assumes: imported whole by the top module and the memory module
package bdf_pkg;

  // data path and storage
  localparam int BDF_WIDTH = 36;
  localparam int BDF_DEPTH = 8192;
  localparam int BDF_BUF_ENTRIES = 2;

  // preset almost-flag offsets, in locations from the boundary
  localparam int BDF_OFF_PRESET_1 = 8;
  localparam int BDF_OFF_PRESET_2 = 16;
  localparam int BDF_OFF_PRESET_3 = 64;
  localparam int BDF_OFF_RESET = 8;

  // offset selector codes, {offset_select_hi, offset_select_lo}
  localparam logic [1:0] BDF_FS_PROGRAM = 2'h0;
  localparam logic [1:0] BDF_FS_PRESET_1 = 2'h1;
  localparam logic [1:0] BDF_FS_PRESET_2 = 2'h2;
  localparam logic [1:0] BDF_FS_PRESET_3 = 2'h3;

  // offset table slots, also the load order of the four program writes
  localparam int BDF_SLOT_AE_B = 0;
  localparam int BDF_SLOT_AF_A = 1;
  localparam int BDF_SLOT_AE_A = 2;
  localparam int BDF_SLOT_AF_B = 3;
  localparam logic [1:0] BDF_LOAD_LAST = 2'h3;

  // offset programming state
  typedef enum logic [0:0] {
    BDF_LD_IDLE = 1'b0,
    BDF_LD_ACTIVE = 1'b1
  } bdf_load_t;

endpackage

// ===== pkg/bdf_mem_if.sv
// bdf_mem_if: one write port and one read port into a fifo storage array
// assumes: ctrl side drives strobes and addresses, mem side returns registered data
`timescale 1ns/1ps
interface bdf_mem_if #(
  parameter int W = 36,
  parameter int AW = 13
);
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// ===== design/bdf_mem.sv
// bdf_mem: simple dual-port storage array with registered read data
// assumes: one clock; read data valid the cycle after re
`timescale 1ns/1ps
module bdf_mem
  import bdf_pkg::*;
#(
  parameter int W = BDF_WIDTH,
  parameter int DEPTH = BDF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic i_clk,
  // storage port
  bdf_mem_if.mem bus
);

  logic [W-1:0] ram [DEPTH];
  logic [W-1:0] rdata_reg;

  // write and registered read
  always_ff @(posedge i_clk) begin
    if (bus.we) begin
      ram[bus.waddr] <= bus.wdata;
    end
    if (bus.re) begin
      rdata_reg <= ram[bus.raddr];
    end
  end

  assign bus.rdata = rdata_reg;

endmodule // bdf_mem

// ===== design/bdf_top.sv
// bdf_top: two opposite fifos with mailboxes, flags and port decode
// assumes: port clocks are plain inputs synchronous to i_clk, sampled for rising edges
`timescale 1ns/1ps
module bdf_top
  import bdf_pkg::*;
#(
  parameter int W = BDF_WIDTH,
  parameter int DEPTH = BDF_DEPTH
) (
  // clock and block reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // shared mode and offset strap inputs
  input wire logic i_fall_through_select,
  input wire logic i_offset_select_lo,
  input wire logic i_offset_select_hi,
  input wire logic i_a_to_b_fifo_reset_n,
  input wire logic i_b_to_a_fifo_reset_n,
  // port A control
  input wire logic i_port_a_clock,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_enable,
  input wire logic i_port_a_write_read_select,
  input wire logic i_port_a_mailbox_select,
  // port A data pin
  input wire logic [W-1:0] i_port_a_data,
  output logic [W-1:0] o_port_a_data,
  output logic o_port_a_data_oe,
  // port A flags
  output logic o_port_a_empty_or_out_ready,
  output logic o_port_a_full_or_in_ready,
  output logic o_port_a_almost_empty_n,
  output logic o_port_a_almost_full_n,
  output logic o_b_to_a_mail_flag,
  // port B control
  input wire logic i_port_b_clock,
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_enable,
  input wire logic i_port_b_write_read_select,
  input wire logic i_port_b_mailbox_select,
  // port B data pin
  input wire logic [W-1:0] i_port_b_data,
  output logic [W-1:0] o_port_b_data,
  output logic o_port_b_data_oe,
  // port B flags
  output logic o_port_b_empty_or_out_ready,
  output logic o_port_b_full_or_in_ready,
  output logic o_port_b_almost_empty_n,
  output logic o_port_b_almost_full_n,
  output logic o_a_to_b_mail_flag
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  //////////////////////////////////////////////////////////////////////////////
  // state: index 0 is port A / A-to-B fifo, index 1 is port B / B-to-A fifo

  typedef struct packed {
    logic [1:0] clk_prev;
    logic [1:0] frst_prev;
    logic [1:0][AW-1:0] wp;
    logic [1:0][AW-1:0] rp;
    logic [1:0][CW-1:0] mcnt;
    logic [1:0] infl;
    logic [1:0][1:0][W-1:0] bufd;
    logic [1:0][1:0] bcnt;
    logic [1:0][W-1:0] outr;
    logic [1:0] ovld;
    logic [1:0][W-1:0] mail;
    logic [1:0] mflag;
    logic [3:0][CW-1:0] off;
    bdf_load_t ld;
    logic [1:0] ldcnt;
    logic [1:0] ef_s1;
    logic [1:0] ef_s2;
    logic [1:0] ff_s1;
    logic [1:0] ff_s2;
    logic [1:0] ae_s1;
    logic [1:0] ae_s2;
    logic [1:0] af_s1;
    logic [1:0] af_s2;
    logic [1:0][W-1:0] dout;
    logic [1:0] doe;
  } bdf_state_t;

  bdf_state_t st_reg;
  bdf_state_t st_next;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // write/read decode; port B polarity is inverted
  function automatic logic port_write(input int p, input logic sel);
    return (p == 0) ? sel : ~sel;
  endfunction

  // words held: array, in flight, buffer and fall-through output word
  function automatic logic [CW-1:0] stored_words(input logic [CW-1:0] m, input logic inf,
                                                 input logic [1:0] b, input logic ov);
    return m + CW'(inf) + CW'(b) + CW'(ov);
  endfunction

  // preset offset for a nonzero selector code
  function automatic logic [CW-1:0] preset_offset(input logic [1:0] fs);
    logic [CW-1:0] v;
    v = CW'(BDF_OFF_PRESET_3);
    if (fs == BDF_FS_PRESET_1) begin
      v = CW'(BDF_OFF_PRESET_1);
    end else if (fs == BDF_FS_PRESET_2) begin
      v = CW'(BDF_OFF_PRESET_2);
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin grouping and storage

  logic [1:0] clk_in, cs_n, en, wrsel, mbx, frst_n;
  logic [1:0][W-1:0] din;
  logic [1:0][W-1:0] rdata;
  logic [1:0] edge_p, acc, wr_op, rd_op, fw, re, pop, rdf;
  logic [1:0][CW-1:0] tot;
  logic [1:0][1:0] bcn;
  logic [1:0] fs;
  logic std_mode, ld_wr;

  assign clk_in = {i_port_b_clock, i_port_a_clock};
  assign cs_n = {i_port_b_select_n, i_port_a_select_n};
  assign en = {i_port_b_enable, i_port_a_enable};
  assign wrsel = {i_port_b_write_read_select, i_port_a_write_read_select};
  assign mbx = {i_port_b_mailbox_select, i_port_a_mailbox_select};
  assign frst_n = {i_b_to_a_fifo_reset_n, i_a_to_b_fifo_reset_n};
  assign din = {i_port_b_data, i_port_a_data};
  assign fs = {i_offset_select_hi, i_offset_select_lo};
  assign std_mode = i_fall_through_select;

  bdf_mem_if #(.W(W), .AW(AW)) mif [2] ();

  // one storage array per direction
  for (genvar g = 0; g < 2; g++) begin : g_mem
    assign mif[g].we = fw[g];
    assign mif[g].waddr = st_reg.wp[g];
    assign mif[g].wdata = din[g];
    assign mif[g].re = re[g];
    assign mif[g].raddr = st_reg.rp[g];
    assign rdata[g] = mif[g].rdata;
    bdf_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .i_clk(i_clk),
      .bus(mif[g].mem)
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    st_next.clk_prev = clk_in;
    st_next.frst_prev = frst_n;
    // port decode on each port clock rising edge
    for (int p = 0; p < 2; p++) begin
      edge_p[p] = clk_in[p] & ~st_reg.clk_prev[p];
      acc[p] = edge_p[p] & ~cs_n[p] & en[p];
      wr_op[p] = acc[p] & port_write(p, wrsel[p]);
      rd_op[p] = acc[p] & ~port_write(p, wrsel[p]);
      tot[p] = stored_words(st_reg.mcnt[p], st_reg.infl[p], st_reg.bcnt[p], st_reg.ovld[p]);
    end
    // offset programming through port A fifo writes
    ld_wr = wr_op[0] & ~mbx[0] & (st_reg.ld == BDF_LD_ACTIVE);
    if (ld_wr) begin
      st_next.off[st_reg.ldcnt] = din[0][CW-1:0];
      st_next.ldcnt = st_reg.ldcnt + 2'h1;
      if (st_reg.ldcnt == BDF_LOAD_LAST) begin
        st_next.ld = BDF_LD_IDLE;
      end
    end
    // per fifo: write, prefetch into two-entry buffer, read
    for (int d = 0; d < 2; d++) begin
      fw[d] = wr_op[d] & ~mbx[d] & (tot[d] < DEPTH_C) & frst_n[d]
              & ~((d == 0) && (st_reg.ld == BDF_LD_ACTIVE));
      rdf[d] = rd_op[1-d] & ~mbx[1-d];
      pop[d] = (st_reg.bcnt[d] != 2'h0) & frst_n[d]
               & (std_mode ? rdf[d] : (~st_reg.ovld[d] | rdf[d]));
      re[d] = (st_reg.mcnt[d] != '0) & frst_n[d]
              & (({1'b0, st_reg.bcnt[d]} + {2'h0, st_reg.infl[d]}) < 3'(BDF_BUF_ENTRIES));
      if (pop[d]) begin
        st_next.outr[d] = st_reg.bufd[d][0];
        st_next.bufd[d][0] = st_reg.bufd[d][1];
        st_next.ovld[d] = ~std_mode;
      end else if (~std_mode & rdf[d] & st_reg.ovld[d]) begin
        st_next.ovld[d] = 1'b0;
      end
      bcn[d] = st_reg.bcnt[d] - {1'b0, pop[d]};
      if (st_reg.infl[d]) begin
        st_next.bufd[d][bcn[d][0]] = rdata[d];
        bcn[d] = bcn[d] + 2'h1;
      end
      st_next.bcnt[d] = bcn[d];
      st_next.mcnt[d] = st_reg.mcnt[d] + CW'(fw[d]) - CW'(re[d]);
      st_next.wp[d] = st_reg.wp[d] + AW'(fw[d]);
      st_next.rp[d] = st_reg.rp[d] + AW'(re[d]);
      st_next.infl[d] = re[d];
      // fifo reset clears storage and frees the mailbox
      if (~frst_n[d]) begin
        st_next.wp[d] = '0;
        st_next.rp[d] = '0;
        st_next.mcnt[d] = '0;
        st_next.infl[d] = 1'b0;
        st_next.bcnt[d] = 2'h0;
        st_next.ovld[d] = 1'b0;
        st_next.mflag[d] = 1'b1;
      end
      // offset selection latched on reset release
      if (frst_n[d] & ~st_reg.frst_prev[d] & (fs != BDF_FS_PROGRAM)) begin
        st_next.off[2*d] = preset_offset(fs);
        st_next.off[2*d+1] = preset_offset(fs);
      end
    end
    // both released together with selectors low: program offsets
    if ((&frst_n) & ~(|st_reg.frst_prev) & (fs == BDF_FS_PROGRAM)) begin
      st_next.ld = BDF_LD_ACTIVE;
      st_next.ldcnt = 2'h0;
    end
    // mailbox reads free the opposite box, then writes claim their own
    for (int p = 0; p < 2; p++) begin
      if (rd_op[p] & mbx[p]) begin
        st_next.mflag[1-p] = 1'b1;
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (wr_op[p] & mbx[p] & st_reg.mflag[p] & frst_n[p]) begin
        st_next.mail[p] = din[p];
        st_next.mflag[p] = 1'b0;
      end
    end
    // flags: two stages, advanced on the owning port clock edge
    for (int p = 0; p < 2; p++) begin
      if (edge_p[p]) begin
        st_next.ef_s1[p] = std_mode ? (tot[1-p] != '0) : st_reg.ovld[1-p];
        st_next.ef_s2[p] = st_reg.ef_s1[p];
        st_next.ff_s1[p] = tot[p] < DEPTH_C;
        st_next.ff_s2[p] = st_reg.ff_s1[p];
        st_next.ae_s1[p] = tot[1-p] > st_reg.off[2*(1-p)];
        st_next.ae_s2[p] = st_reg.ae_s1[p];
        st_next.af_s1[p] = (DEPTH_C - tot[p]) > st_reg.off[2*p+1];
        st_next.af_s2[p] = st_reg.af_s1[p];
      end
      // output mux and pin drive
      st_next.dout[p] = mbx[p] ? st_reg.mail[1-p] : st_reg.outr[1-p];
      st_next.doe[p] = ~cs_n[p] & ~port_write(p, wrsel[p]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.mflag <= 2'h3;
      st_reg.clk_prev <= clk_in; // no false port edge out of reset
      st_reg.frst_prev <= frst_n; // no false fifo release out of reset
      st_reg.off <= {4{CW'(BDF_OFF_RESET)}};
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_port_a_data = st_reg.dout[0];
  assign o_port_a_data_oe = st_reg.doe[0];
  assign o_port_b_data = st_reg.dout[1];
  assign o_port_b_data_oe = st_reg.doe[1];
  assign o_port_a_empty_or_out_ready = st_reg.ef_s2[0];
  assign o_port_b_empty_or_out_ready = st_reg.ef_s2[1];
  assign o_port_a_full_or_in_ready = st_reg.ff_s2[0];
  assign o_port_b_full_or_in_ready = st_reg.ff_s2[1];
  assign o_port_a_almost_empty_n = st_reg.ae_s2[0];
  assign o_port_b_almost_empty_n = st_reg.ae_s2[1];
  assign o_port_a_almost_full_n = st_reg.af_s2[0];
  assign o_port_b_almost_full_n = st_reg.af_s2[1];
  assign o_a_to_b_mail_flag = st_reg.mflag[0];
  assign o_b_to_a_mail_flag = st_reg.mflag[1];

endmodule // bdf_top

// ===== bench/bdf_clk_model.sv
// bdf_clk_model: free-running port clocks standing in for the two bus masters
// assumes: one i_clk; port clocks are plain levels sampled by the block
`timescale 1ns/1ps
module bdf_clk_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // port clocks
  output logic o_port_a_clock,
  output logic o_port_b_clock
);
  logic [1:0] cnt_a_reg;
  logic [2:0] cnt_b_reg;

  // port a divides by four, port b by six, so phases drift apart
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_a_reg <= 2'h0;
      cnt_b_reg <= 3'h1;
    end else begin
      cnt_a_reg <= cnt_a_reg + 2'h1;
      cnt_b_reg <= (cnt_b_reg == 3'h5) ? 3'h0 : cnt_b_reg + 3'h1;
    end
  end

  assign o_port_a_clock = cnt_a_reg[1];
  assign o_port_b_clock = (cnt_b_reg > 3'h2);
endmodule // bdf_clk_model

// ===== bench/bdf_properties.sv
// bdf_properties: concurrent checks on the top module ports
// assumes: port clocks sampled on i_clk; bound into every bdf_top
`timescale 1ns/1ps
module bdf_properties (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_a_to_b_fifo_reset_n,
  input wire logic i_b_to_a_fifo_reset_n,
  // port a
  input wire logic i_port_a_clock,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_enable,
  input wire logic i_port_a_write_read_select,
  input wire logic i_port_a_mailbox_select,
  input wire logic o_port_a_data_oe,
  input wire logic o_b_to_a_mail_flag,
  // port b
  input wire logic i_port_b_clock,
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_enable,
  input wire logic i_port_b_write_read_select,
  input wire logic i_port_b_mailbox_select,
  input wire logic o_port_b_data_oe,
  input wire logic o_port_b_empty_or_out_ready,
  input wire logic o_a_to_b_mail_flag
);
  logic pa_reg;
  logic pb_reg;
  logic ev_a;
  logic ev_b;
  logic rise_b;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // port clock edge and access detection
  always_ff @(posedge i_clk) begin
    pa_reg <= i_port_a_clock;
    pb_reg <= i_port_b_clock;
  end
  assign rise_b = i_port_b_clock && !pb_reg;
  assign ev_a = i_port_a_clock && !pa_reg && !i_port_a_select_n && i_port_a_enable;
  assign ev_b = rise_b && !i_port_b_select_n && i_port_b_enable;

  //////////////////////////////////////////////////////////////////////////////
  // mailbox steps
  sequence s_a_mwr;
    ev_a && i_port_a_write_read_select && i_port_a_mailbox_select
      && i_a_to_b_fifo_reset_n && o_a_to_b_mail_flag;
  endsequence
  sequence s_b_mwr;
    ev_b && !i_port_b_write_read_select && i_port_b_mailbox_select
      && i_b_to_a_fifo_reset_n && o_b_to_a_mail_flag;
  endsequence
  sequence s_a_mrd;
    ev_a && !i_port_a_write_read_select && i_port_a_mailbox_select;
  endsequence
  sequence s_b_mrd;
    ev_b && i_port_b_write_read_select && i_port_b_mailbox_select;
  endsequence

  property p_mfa_set; s_a_mwr |=> !o_a_to_b_mail_flag; endproperty
  a_mfa_set: assert property (p_mfa_set) else $error("a-to-b flag not set");
  property p_mfa_keep; o_a_to_b_mail_flag && !ev_a |=> o_a_to_b_mail_flag; endproperty
  a_mfa_keep: assert property (p_mfa_keep) else $error("a-to-b flag fell");
  property p_mfa_clr; s_b_mrd ##0 !ev_a |=> o_a_to_b_mail_flag; endproperty
  a_mfa_clr: assert property (p_mfa_clr) else $error("a-to-b flag kept");
  property p_mfa_rst; !i_a_to_b_fifo_reset_n |=> o_a_to_b_mail_flag; endproperty
  a_mfa_rst: assert property (p_mfa_rst) else $error("a-to-b flag in reset");
  property p_mfb_set; s_b_mwr |=> !o_b_to_a_mail_flag; endproperty
  a_mfb_set: assert property (p_mfb_set) else $error("b-to-a flag not set");
  property p_mfb_clr; s_a_mrd ##0 !ev_b |=> o_b_to_a_mail_flag; endproperty
  a_mfb_clr: assert property (p_mfb_clr) else $error("b-to-a flag kept");

  //////////////////////////////////////////////////////////////////////////////
  // pin drive and flag timing
  property p_oe_a; !i_port_a_select_n && !i_port_a_write_read_select |=> o_port_a_data_oe;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("port a not driving");
  property p_hiz_a; i_port_a_select_n || i_port_a_write_read_select |=> !o_port_a_data_oe;
  endproperty
  a_hiz_a: assert property (p_hiz_a) else $error("port a driving");
  property p_oe_b; !i_port_b_select_n && i_port_b_write_read_select |=> o_port_b_data_oe;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port b not driving");
  property p_hiz_b; i_port_b_select_n || !i_port_b_write_read_select |=> !o_port_b_data_oe;
  endproperty
  a_hiz_b: assert property (p_hiz_b) else $error("port b driving");
  property p_efb_sync;
    $past(i_rst_n, 2) && $changed(o_port_b_empty_or_out_ready) |-> $past(rise_b);
  endproperty
  a_efb_sync: assert property (p_efb_sync) else $error("port b flag off edge");
endmodule // bdf_properties

bind bdf_top bdf_properties bdf_properties_i (.*);

// ===== bench/tb.sv
// tb: port access tests of the two-way fifo block
// assumes: depth 32; standard timing with preset 8, then fall-through with loaded offsets
`timescale 1ns/1ps
module tb;
  logic i_clk, i_rst_n, i_fall_through_select, i_offset_select_lo, i_offset_select_hi;
  logic i_a_to_b_fifo_reset_n, i_b_to_a_fifo_reset_n;
  logic i_port_a_clock, i_port_a_select_n, i_port_a_enable;
  logic i_port_a_write_read_select, i_port_a_mailbox_select;
  logic i_port_b_clock, i_port_b_select_n, i_port_b_enable;
  logic i_port_b_write_read_select, i_port_b_mailbox_select;
  logic [35:0] i_port_a_data, i_port_b_data, o_port_a_data, o_port_b_data;
  logic o_port_a_data_oe, o_port_a_empty_or_out_ready, o_port_a_full_or_in_ready;
  logic o_port_a_almost_empty_n, o_port_a_almost_full_n, o_b_to_a_mail_flag;
  logic o_port_b_data_oe, o_port_b_empty_or_out_ready, o_port_b_full_or_in_ready;
  logic o_port_b_almost_empty_n, o_port_b_almost_full_n, o_a_to_b_mail_flag;
  logic [35:0] md [2] = '{36'h123456789, 36'hfedcba987};
  int n_fail = 0;
  int num_checks = 0;
  int i;
  int j;

  bdf_top #(.DEPTH(32)) bdf_top_i (.*);
  bdf_clk_model bdf_clk_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .o_port_a_clock(i_port_a_clock), .o_port_b_clock(i_port_b_clock));

  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // one access on the next port clock rise; wr means write on either port
  task automatic op(input bit pb, input bit wr, input bit mbx, input bit en, input bit cs,
                    input logic [35:0] d);
    int k;
    int w;
    for (w = 0; w < 16 && (pb ? i_port_b_clock : i_port_a_clock); w++) tick(1);
    for (k = 0; k < 16 && !(pb ? i_port_b_clock : i_port_a_clock); k++) tick(1);
    if (k == 16 || w == 16) begin
      n_fail++;
      $display("[FAIL] %0t port clock stuck", $time);
      give_verdict();
    end
    if (pb) begin
      i_port_b_select_n = !cs;
      i_port_b_enable = en;
      i_port_b_write_read_select = !wr;
      i_port_b_mailbox_select = mbx;
      i_port_b_data = d;
    end else begin
      i_port_a_select_n = !cs;
      i_port_a_enable = en;
      i_port_a_write_read_select = wr;
      i_port_a_mailbox_select = mbx;
      i_port_a_data = d;
    end
    tick(1);
    i_port_a_enable = 0;
    i_port_b_enable = 0;
  endtask

  task automatic rd(input bit pb, input bit mbx, input logic [35:0] e);
    op(pb, 0, mbx, 1, 1, 36'h0);
    tick(3);
    chk((pb ? o_port_b_data : o_port_a_data) === e, "read data");
    chk((pb ? o_port_b_data_oe : o_port_a_data_oe) === 1'b1, "read pins");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_rst_n, i_a_to_b_fifo_reset_n, i_b_to_a_fifo_reset_n} = 3'h0;
    {i_fall_through_select, i_offset_select_lo, i_offset_select_hi} = 3'h6;
    {i_port_a_select_n, i_port_a_enable, i_port_a_write_read_select} = 3'h4;
    {i_port_b_select_n, i_port_b_enable, i_port_b_write_read_select} = 3'h5;
    i_port_a_mailbox_select = 0;
    i_port_b_mailbox_select = 0;
    i_port_a_data = 36'h0;
    i_port_b_data = 36'h0;
    tick(12);
    i_rst_n = 1;
    // more than four edges of each port clock with both fifo resets low
    tick(30);
    i_a_to_b_fifo_reset_n = 1;
    i_b_to_a_fifo_reset_n = 1;
    tick(20);
    chk(o_a_to_b_mail_flag === 1'b1 && o_b_to_a_mail_flag === 1'b1, "mail flags");
    chk({o_port_a_empty_or_out_ready, o_port_b_empty_or_out_ready} === 2'h0, "empty");
    chk({o_port_a_full_or_in_ready, o_port_b_full_or_in_ready} === 2'h3, "space");
    chk({o_port_a_almost_empty_n, o_port_b_almost_empty_n, o_port_a_almost_full_n,
         o_port_b_almost_full_n} === 4'h3, "almost flags");
    chk(o_port_a_data_oe === 1'b0 && o_port_b_data_oe === 1'b0, "pins float");
    // mailbox both ways, second write blocked
    for (i = 0; i < 2; i++) begin
      op(i[0], 1, 1, 1, 1, md[i]);
      tick(3);
      chk((i ? o_b_to_a_mail_flag : o_a_to_b_mail_flag) === 1'b0, "flag low");
      chk((i ? o_port_b_data_oe : o_port_a_data_oe) === 1'b0, "write floats");
      op(i[0], 1, 1, 1, 1, ~md[i]);
      rd(!i[0], 1, md[i]);
      tick(3);
      chk((i ? o_b_to_a_mail_flag : o_a_to_b_mail_flag) === 1'b1, "flag high");
    end
    // ignored writes, then fill a-to-b past full
    op(0, 1, 0, 0, 1, 36'hbad);
    op(0, 1, 0, 1, 0, 36'hbad);
    for (i = 0; i < 33; i++) begin
      op(0, 1, 0, 1, 1, 36'h100 + 36'(i));
      tick(14);
      if (i == 7 || i == 8)
        chk(o_port_b_almost_empty_n === (i == 8), "almost empty");
      if (i == 22 || i == 23)
        chk(o_port_a_almost_full_n === (i == 22), "almost full");
    end
    chk(o_port_a_full_or_in_ready === 1'b0, "full");
    chk(o_port_b_empty_or_out_ready === 1'b1, "not empty");
    for (i = 0; i < 32; i++) rd(1, 0, 36'h100 + 36'(i));
    tick(14);
    chk(o_port_b_empty_or_out_ready === 1'b0, "drained");
    chk(o_port_a_full_or_in_ready === 1'b1, "space back");
    // second reset: fall-through timing, offsets loaded by four port A writes
    i_rst_n = 0;
    {i_a_to_b_fifo_reset_n, i_b_to_a_fifo_reset_n} = 2'h0;
    {i_fall_through_select, i_offset_select_lo, i_offset_select_hi} = 3'h0;
    tick(12);
    i_rst_n = 1;
    tick(30);
    {i_a_to_b_fifo_reset_n, i_b_to_a_fifo_reset_n} = 2'h3;
    for (i = 0; i < 4; i++) op(0, 1, 0, 1, 1, 36'(i + 2));
    tick(14);
    chk({o_port_b_empty_or_out_ready, o_port_b_almost_empty_n} === 2'h0, "loads kept out");
    // three words a to b, then five words b to a; almost-empty offsets 2 and 4
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 3 + 2 * j; i++) begin
        op(j[0], 1, 0, 1, 1, 36'h200 + 36'(256 * j + i));
        tick(14);
        chk((j ? o_port_a_almost_empty_n : o_port_b_almost_empty_n) === (i > 2 * j + 1),
            "loaded almost empty");
      end
      chk((j ? o_port_a_empty_or_out_ready : o_port_b_empty_or_out_ready) === 1'b1,
          "out ready");
      for (i = 0; i < 3 + 2 * j; i++) begin
        chk((j ? o_port_a_data : o_port_b_data) === 36'h200 + 36'(256 * j + i),
            "fall-through word");
        op(!j[0], 0, 0, 1, 1, 36'h0);
        tick(3);
      end
      tick(14);
      chk((j ? o_port_a_empty_or_out_ready : o_port_b_empty_or_out_ready) === 1'b0,
          "out ready low");
    end
    give_verdict();
  end
endmodule // tb
